//--- pocs_sequencer.sv
// Purpose: Power-on reset and configuration sequencer for a flash-based logic device.
// Assumes: Supply indications and global pins are synchronous to clock_i.
// Notes:   The flash-to-SRAM copier reports completion on dl_done_i.
`timescale 1ns/1ps
module pocs_sequencer #(
    parameter int                     IO_BANKS = pocs_pkg::IO_BANKS,
    parameter logic [pocs_pkg::CFG_CNT_W-1:0] CFG_CYC =
        pocs_pkg::CFG_CNT_W'(pocs_pkg::CFG_CYC)
) (
    // Clock and reset.
    input  wire logic                     clock_i,
    input  wire logic                     rst_b_i,
    // Supply indications.
    input  wire pocs_pkg::pocs_core_s     core_supply_i,
    input  wire logic [IO_BANKS-1:0]      io_bank_supply_good_i,
    // Configuration copier.
    input  wire logic                     dl_done_i,
    // Optional global pins and their enables.
    input  wire logic                     gclr_enable_i,
    input  wire logic                     global_register_clear_pin_b_i,
    input  wire logic                     goe_enable_i,
    input  wire logic                     global_output_enable_pin_i,
    // Controls to the device.
    output pocs_pkg::pocs_pin_ctrl_s      pin_ctrl_o,
    output pocs_pkg::pocs_cfg_ctrl_s      cfg_ctrl_o
);

    localparam logic [pocs_pkg::LATE_CNT_W-1:0] LATE_LAST =
        pocs_pkg::LATE_CNT_W'(pocs_pkg::LATE_CYC - 1);

    pocs_pkg::pocs_state_e                st_q;
    logic [pocs_pkg::CFG_CNT_W-1:0]       cfg_cnt_q;
    logic                                 cfg_expired_q;
    logic [pocs_pkg::LATE_CNT_W-1:0]      late_cnt_q;
    pocs_pkg::pocs_pin_ctrl_s             pin_q;
    pocs_pkg::pocs_cfg_ctrl_s             cfg_q;
    logic                                 io_all_good;
    logic                                 gclr_hold;
    logic                                 goe_hold;

    // A bank that never powers keeps the device out of user mode for good.
    assign io_all_good = &io_bank_supply_good_i;
    // The global pins act only when their option is enabled.
    assign gclr_hold   = gclr_enable_i & ~global_register_clear_pin_b_i;
    assign goe_hold    = goe_enable_i & ~global_output_enable_pin_i;
    assign pin_ctrl_o  = pin_q;
    assign cfg_ctrl_o  = cfg_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencing state.
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= pocs_pkg::PS_OFF;
        end else begin
            case (st_q)
                pocs_pkg::PS_OFF: begin
                    if (core_supply_i.core_above_start) begin
                        st_q <= pocs_pkg::PS_LOAD;
                    end
                end
                pocs_pkg::PS_LOAD: begin
                    if (!core_supply_i.core_above_brownout) begin
                        st_q <= pocs_pkg::PS_OFF;
                    end else if (dl_done_i) begin
                        st_q <= pocs_pkg::PS_WAIT_IO;
                    end
                end
                pocs_pkg::PS_WAIT_IO: begin
                    if (!core_supply_i.core_above_brownout) begin
                        st_q <= pocs_pkg::PS_OFF;
                    end else if (io_all_good && !cfg_expired_q) begin
                        st_q <= pocs_pkg::PS_CLEAR;
                    end else if (io_all_good) begin
                        st_q <= pocs_pkg::PS_LATE;
                    end
                end
                pocs_pkg::PS_LATE: begin
                    if (!core_supply_i.core_above_brownout) begin
                        st_q <= pocs_pkg::PS_OFF;
                    end else if (!io_all_good) begin
                        st_q <= pocs_pkg::PS_WAIT_IO;
                    end else if (late_cnt_q == LATE_LAST) begin
                        st_q <= pocs_pkg::PS_CLEAR;
                    end
                end
                // The two clear steps ignore a brown-out; USER catches it a cycle or
                // two later, which keeps the clear-before-release order intact.
                // clear then release
                pocs_pkg::PS_CLEAR: begin
                    st_q <= pocs_pkg::PS_RELEASE;
                end
                pocs_pkg::PS_RELEASE: begin
                    st_q <= pocs_pkg::PS_USER;
                end
                pocs_pkg::PS_USER: begin
                    if (!core_supply_i.core_above_brownout) begin
                        st_q <= pocs_pkg::PS_OFF;
                    end
                end
                default: begin
                    st_q <= pocs_pkg::PS_OFF;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration-time and late-bank counters.
    // The timer stops once expired, so it cannot wrap and re-arm the early path.
    // counted time base
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_cnt_q     <= '0;
            cfg_expired_q <= 1'b0;
        end else if (st_q == pocs_pkg::PS_OFF) begin
            cfg_cnt_q     <= '0;
            cfg_expired_q <= 1'b0;
        end else if (!cfg_expired_q) begin
            cfg_cnt_q     <= cfg_cnt_q + 1'b1;
            cfg_expired_q <= (cfg_cnt_q == CFG_CYC - 1'b1);
        end
    end

    // The count restarts whenever a bank drops, since LATE is then left.
    // two microsecond delay
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            late_cnt_q <= '0;
        end else if (st_q == pocs_pkg::PS_LATE) begin
            late_cnt_q <= late_cnt_q + 1'b1;
        end else begin
            late_cnt_q <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin and configuration controls, all registered.
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_q.io_tristate  <= pocs_pkg::RST_IO_TRISTATE;
            pin_q.io_pullup_en <= pocs_pkg::RST_IO_PULLUP;
            pin_q.reg_clear    <= pocs_pkg::RST_REG_CLEAR;
            pin_q.supply_low_isolate <= pocs_pkg::RST_ISOLATE;
        end else begin
            pin_q.io_tristate  <= (st_q != pocs_pkg::PS_USER) || goe_hold;
            pin_q.io_pullup_en <= (st_q != pocs_pkg::PS_USER);
            pin_q.reg_clear    <= (st_q != pocs_pkg::PS_RELEASE &&
                                   st_q != pocs_pkg::PS_USER) || gclr_hold;
            // Isolation follows the supplies alone, not the sequencing state, so
            // it cuts the buffers even before a download has started.
            // isolate on low supply
            pin_q.supply_low_isolate <= !core_supply_i.core_above_brownout || !io_all_good;
        end
    end

    // The SRAM is held in reset whenever the sequencer is off, so a brown-out
    // always leaves a clean array for the next download.
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_q.sram_reset <= pocs_pkg::RST_SRAM_RESET;
            cfg_q.dl_run     <= pocs_pkg::RST_DL_RUN;
            cfg_q.user_mode  <= pocs_pkg::RST_USER_MODE;
        end else begin
            cfg_q.sram_reset <= (st_q == pocs_pkg::PS_OFF);
            cfg_q.dl_run     <= (st_q == pocs_pkg::PS_LOAD);
            cfg_q.user_mode  <= (st_q == pocs_pkg::PS_USER);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.
    // Holds from the global pins act one cycle late, so checks that meet them
    // compare against the pins' value at the launching edge.
    sequence s_clear_release;
        (st_q == pocs_pkg::PS_CLEAR) ##1 (st_q == pocs_pkg::PS_RELEASE);
    endsequence

    sequence s_release_user;
        (st_q == pocs_pkg::PS_USER) ##1 (!pin_q.reg_clear || $past(gclr_hold));
    endsequence

    property p_pending_tristate;
        @(posedge clock_i) disable iff (!rst_b_i)
        (st_q == pocs_pkg::PS_LOAD) |=> (pin_q.io_tristate && pin_q.io_pullup_en);
    endproperty
    a_pending_tristate: assert property (p_pending_tristate)
        else $error("Pins not tri-stated with pull-ups during download.");

    property p_user_release;
        @(posedge clock_i) disable iff (!rst_b_i)
        (st_q == pocs_pkg::PS_USER && !goe_enable_i) |=> !pin_q.io_tristate;
    endproperty
    a_user_release: assert property (p_user_release)
        else $error("Pins still tri-stated in user mode.");

    property p_start_load;
        @(posedge clock_i) disable iff (!rst_b_i)
        (st_q == pocs_pkg::PS_OFF && core_supply_i.core_above_start)
            |=> (st_q == pocs_pkg::PS_LOAD) ##1 cfg_q.dl_run;
    endproperty
    a_start_load: assert property (p_start_load)
        else $error("Download did not start at the threshold.");

    property p_banks_gate;
        @(posedge clock_i) disable iff (!rst_b_i)
        $rose(st_q == pocs_pkg::PS_CLEAR) |-> $past(io_all_good);
    endproperty
    a_banks_gate: assert property (p_banks_gate)
        else $error("User entry began without all banks good.");

    property p_together_in_time;
        @(posedge clock_i) disable iff (!rst_b_i)
        (st_q == pocs_pkg::PS_WAIT_IO && io_all_good && !cfg_expired_q &&
         core_supply_i.core_above_brownout) |=> s_clear_release ##1 s_release_user;
    endproperty
    a_together_in_time: assert property (p_together_in_time)
        else $error("Early banks did not lead straight to user mode.");

    property p_late_wait;
        @(posedge clock_i) disable iff (!rst_b_i)
        (st_q == pocs_pkg::PS_LATE && late_cnt_q != LATE_LAST && io_all_good &&
         core_supply_i.core_above_brownout) |=> (st_q == pocs_pkg::PS_LATE);
    endproperty
    a_late_wait: assert property (p_late_wait)
        else $error("Late-bank delay cut short.");

    property p_core_only;
        @(posedge clock_i) disable iff (!rst_b_i)
        (st_q == pocs_pkg::PS_USER && core_supply_i.core_above_brownout)
            |=> (st_q == pocs_pkg::PS_USER);
    endproperty
    a_core_only: assert property (p_core_only)
        else $error("User mode left while core supply was good.");

    property p_brownout;
        @(posedge clock_i) disable iff (!rst_b_i)
        (st_q == pocs_pkg::PS_USER && !core_supply_i.core_above_brownout)
            |=> ##1 (cfg_q.sram_reset && pin_q.io_tristate && !cfg_q.user_mode);
    endproperty
    a_brownout: assert property (p_brownout)
        else $error("Brown-out did not reset SRAM and tri-state pins.");

    property p_clear_first;
        @(posedge clock_i) disable iff (!rst_b_i)
        $fell(pin_q.io_tristate) |-> ($past(!pin_q.reg_clear) || $past(gclr_hold, 2));
    endproperty
    a_clear_first: assert property (p_clear_first)
        else $error("Tri-state released before register clears.");

    property p_gclr_hold;
        @(posedge clock_i) disable iff (!rst_b_i)
        gclr_hold |=> pin_q.reg_clear;
    endproperty
    a_gclr_hold: assert property (p_gclr_hold)
        else $error("Global clear hold not honoured.");

    property p_goe_hold;
        @(posedge clock_i) disable iff (!rst_b_i)
        goe_hold |=> pin_q.io_tristate;
    endproperty
    a_goe_hold: assert property (p_goe_hold)
        else $error("Global output-enable hold not honoured.");

    property p_isolate;
        @(posedge clock_i) disable iff (!rst_b_i)
        (!core_supply_i.core_above_brownout || !io_all_good) |=> pin_q.supply_low_isolate;
    endproperty
    a_isolate: assert property (p_isolate)
        else $error("Isolation not raised on low supply.");

endmodule

//--- pocs_pkg.sv
// Purpose: Shared constants and carrier types for the power-on configuration sequencer.
// Assumes: A 10 MHz clock. Supply levels arrive as digital comparator indications.
// Notes:   The comparators themselves sit outside this logic.
package pocs_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and time base.
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_CONFIG_US   = 450;
    localparam int T_LATE_IO_NS  = 2000;
    // A longest time rounds down to whole cycles.
    localparam int CFG_CYC       = (T_CONFIG_US * 1000) / CLK_PERIOD_NS;
    // A least time rounds up to whole cycles.
    localparam int LATE_CYC      = (T_LATE_IO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CFG_CNT_W     = 16;
    localparam int LATE_CNT_W    = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // Comparator trip points in millivolts, for the analog designer's reference.
    localparam int CORE_START_MV    = 1700;
    localparam int CORE_START_LV_MV = 1550;
    localparam int CORE_BROWNOUT_MV = 1400;
    localparam int IO_BANKS         = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Values after reset.
    localparam logic RST_IO_TRISTATE = 1'b1;
    localparam logic RST_IO_PULLUP   = 1'b1;
    localparam logic RST_REG_CLEAR   = 1'b1;
    localparam logic RST_ISOLATE     = 1'b1;
    localparam logic RST_SRAM_RESET  = 1'b1;
    localparam logic RST_DL_RUN      = 1'b0;
    localparam logic RST_USER_MODE   = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // Types.
    typedef enum logic [2:0] {
        PS_OFF,
        PS_LOAD,
        PS_WAIT_IO,
        PS_LATE,
        PS_CLEAR,
        PS_RELEASE,
        PS_USER
    } pocs_state_e;

    typedef struct packed {
        logic core_above_start;
        logic core_above_brownout;
    } pocs_core_s;

    typedef struct packed {
        logic io_tristate;
        logic io_pullup_en;
        logic reg_clear;
        logic supply_low_isolate;
    } pocs_pin_ctrl_s;

    typedef struct packed {
        logic sram_reset;
        logic dl_run;
        logic user_mode;
    } pocs_cfg_ctrl_s;

endpackage

//--- pocs_board.sv
// Purpose: Board supplies, optional global pins and a stand-in for the flash copier.
// Assumes: Levels change only through the tasks, called just after a rising edge.
// Notes:   Pin order is {clear enable, clear pin, output-enable enable, output-enable pin}.
`timescale 1ns/1ps
module pocs_board (
    // Clock and reset.
    input  wire logic            clock_i,
    input  wire logic            rst_b_i,
    // Download status from the sequencer.
    input  wire logic            dl_run_i,
    // Board levels.
    output pocs_pkg::pocs_core_s core_supply_o,
    output logic [3:0]           io_good_o,
    output logic                 dl_done_o,
    output logic [3:0]           gpin_o
);
    int unsigned dl_len_q;
    int unsigned dl_cnt_q;

    initial begin
        core_supply_o = '0;
        io_good_o     = 4'h0;
        gpin_o        = 4'h5;
        dl_len_q      = 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // supply levels
    task automatic set_supply(input logic [1:0] core, input logic [3:0] banks);
        core_supply_o <= core;
        io_good_o     <= banks;
    endtask

    task automatic set_pins(input logic [3:0] pins);
        gpin_o <= pins;
    endtask

    task automatic set_dl(input int unsigned len);
        dl_len_q = len;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Done drops with the run flag, so a stale done cannot leak into a restart.
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dl_cnt_q  <= 0;
            dl_done_o <= 1'b0;
        end else begin
            dl_cnt_q  <= dl_run_i ? dl_cnt_q + 1 : 0;
            dl_done_o <= dl_run_i && (dl_cnt_q >= dl_len_q);
        end
    end
endmodule

//--- testbench.sv
// Purpose: Self-checking bench for the power-on configuration sequencer.
// Assumes: A shortened configuration time; all stimulus but clock and reset passes through the board model.
// Notes:   Notes in the queue carry the negedge number at which they fall due.
`timescale 1ns/1ps
module testbench;
    localparam int CFG       = 40;
    localparam int LATE_WAIT = pocs_pkg::LATE_CYC + 5;

    typedef struct {
        int unsigned              at;
        pocs_pkg::pocs_pin_ctrl_s pin;
        pocs_pkg::pocs_cfg_ctrl_s cfg;
    } pocs_note_s;

    logic                     clock_i;
    logic                     rst_b_i;
    pocs_pkg::pocs_core_s     core;
    logic [3:0]               banks;
    logic                     dl_done;
    logic [3:0]               gpin;
    pocs_pkg::pocs_pin_ctrl_s pin;
    pocs_pkg::pocs_cfg_ctrl_s cfg;
    int                       error_cnt = 0;
    int                       n_tests   = 0;
    int unsigned              ncnt      = 0;
    pocs_note_s               q[$];
    logic [3:0]               pin_tab [4] = '{4'h9, 4'h6, 4'h0, 4'h5};
    logic [3:0]               exp_tab [4] = '{4'h2, 4'h8, 4'h0, 4'h0};

    pocs_sequencer #(.IO_BANKS(4), .CFG_CYC(pocs_pkg::CFG_CNT_W'(CFG))) pocs_sequencer_i (
        .clock_i                       (clock_i),
        .rst_b_i                       (rst_b_i),
        .core_supply_i                 (core),
        .io_bank_supply_good_i         (banks),
        .dl_done_i                     (dl_done),
        .gclr_enable_i                 (gpin[3]),
        .global_register_clear_pin_b_i (gpin[2]),
        .goe_enable_i                  (gpin[1]),
        .global_output_enable_pin_i    (gpin[0]),
        .pin_ctrl_o                    (pin),
        .cfg_ctrl_o                    (cfg)
    );

    pocs_board pocs_board_i (
        .clock_i       (clock_i),
        .rst_b_i       (rst_b_i),
        .dl_run_i      (cfg.dl_run),
        .core_supply_o (core),
        .io_good_o     (banks),
        .dl_done_o     (dl_done),
        .gpin_o        (gpin)
    );

    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic expect_at(input int unsigned k, input logic [3:0] p, input logic [2:0] c);
        q.push_back('{ncnt + k, p, c});
    endtask

    // Counts negedges until user mode, noting where the register clears lifted.
    task automatic wait_user(output int unsigned n);
        int unsigned clr_at;
        clr_at = 0;
        n = 0;
        while (cfg.user_mode !== 1'b1) begin
            @(negedge clock_i);
            n++;
            if (clr_at == 0 && pin.reg_clear === 1'b0)
                clr_at = n;
            if (n > 4 * CFG) begin
                check("user_mode wait", 16'(0), 16'(1));
                report_and_stop();
            end
        end
        check("clear lead", 16'(n - clr_at), 16'(1));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever begin
            @(negedge clock_i);
            ncnt++;
            while (q.size() > 0 && q[0].at <= ncnt) begin
                check("pin_ctrl_o", 16'(pin), 16'(q[0].pin));
                check("cfg_ctrl_o", 16'(cfg), 16'(q[0].cfg));
                void'(q.pop_front());
            end
        end
    end

    initial begin
        int unsigned n;
        logic [3:0]  part;
        rst_b_i = 1'b0;
        n = $urandom(70);
        repeat (2) @(posedge clock_i);
        check("pin reset", 16'(pin), 16'(4'hF));
        check("cfg reset", 16'(cfg), 16'(3'h4));
        rst_b_i <= 1'b1;
        // Supplies rise together.
        pocs_board_i.set_dl(1 + $urandom % 20);
        @(posedge clock_i);
        pocs_board_i.set_supply(2'b11, 4'hF);
        expect_at(3, 4'hE, 3'h2);
        wait_user(n);
        check("together latency", 16'(n <= CFG), 16'(1));
        @(posedge clock_i);
        expect_at(1, 4'h0, 3'h1);
        pocs_board_i.set_supply(2'b11, 4'hB);
        expect_at(3, 4'h1, 3'h1);
        repeat (3) @(posedge clock_i);
        pocs_board_i.set_supply(2'b11, 4'hF);
        foreach (pin_tab[i]) begin
            @(posedge clock_i);
            pocs_board_i.set_pins(pin_tab[i]);
            expect_at(3, exp_tab[i], 3'h1);
            repeat (3) @(posedge clock_i);
        end
        // Brown-out in user mode, then recovery.
        @(posedge clock_i);
        pocs_board_i.set_supply(2'b00, 4'hF);
        expect_at(3, 4'hF, 3'h4);
        repeat (4) @(posedge clock_i);
        pocs_board_i.set_dl(1 + $urandom % 20);
        pocs_board_i.set_supply(2'b11, 4'hF);
        wait_user(n);
        check("restart latency", 16'(n <= CFG), 16'(1));
        // Banks arrive long after the core.
        @(posedge clock_i);
        pocs_board_i.set_supply(2'b00, 4'h0);
        repeat (4) @(posedge clock_i);
        pocs_board_i.set_supply(2'b11, 4'h0);
        repeat (2 * CFG) @(posedge clock_i);
        expect_at(1, 4'hF, 3'h0);
        part = 4'($urandom % 15);
        pocs_board_i.set_supply(2'b11, part);
        repeat (3) @(posedge clock_i);
        expect_at(1, 4'hF, 3'h0);
        pocs_board_i.set_supply(2'b11, 4'hF);
        wait_user(n);
        check("late bank entry", 16'(n), 16'(LATE_WAIT));
        repeat (2) @(posedge clock_i);
        report_and_stop();
    end
endmodule
